// *** design/csd_strap_decoder.sv ***
// Purpose: Resolves tri-level straps and decodes pin or extended control mode
// Assumes: All inputs synchronous to sys_clk; each strap is sensed twice,
//   once with a weak pull-up and once with a weak pull-down applied
// Notes: Settings and serial routing are registered; Avalon-MM slave
//   answers every access one cycle after it is taken
`timescale 1ns/100ps
`include "csd_consts.svh"

// Notes on behaviour
// [R1] Floating mode strap selects extended serial mode
// [R2] Driven mode strap keeps serial inactive, pins control
// [R3] Mode strap low 650 mV, high 870 mV
// [R4] Swing strap low 0.50 V, high 0.70 V
// [R5] Edge strap low negative, high positive edge
// [R6] Floating edge strap gives DDR output clock
// [R7] Calibration strap high long, low short delay
// [R8] Floating calibration strap: short delay, dual-edge sampling
// [R9] Extended mode repurposes straps as serial pins
// [R10] Controller drives mode strap firmly for pin mode
// [R11] Straps resolved to three codes, then registered
module csd_strap_decoder #(
  parameter int NUM_STRAPS = `CSD_NUM_STRAPS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] strap_pu,
  input wire logic [3:0] strap_pd,
  input wire logic ser_sdo,
  input wire logic ser_sdo_oe,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic extended_mode,
  output logic range_870,
  output logic swing_700,
  output logic output_edge_select,
  output logic ddr_mode,
  output logic calibration_delay_select,
  output logic des_enable,
  output logic serial_clock_in,
  output logic serial_chip_select,
  output logic serial_data_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe
);

  // The decode below is written for exactly four straps; refused at elaboration
  if (NUM_STRAPS != `CSD_NUM_STRAPS)
  begin : g_bad_straps
    $error("csd_strap_decoder serves exactly four straps");
  end

  csd_pkg::csd_state_t state;
  csd_pkg::csd_state_t next_state;
  csd_pkg::csd_level_t [3:0] level;

  // [R11] Three-code resolution
  // Pull-up sense high but pull-down sense low means nobody drives the pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_STRAPS; gi++)
    begin : g_strap
      always_comb
      begin
        if (strap_pu[gi] && strap_pd[gi])
        begin
          level[gi] = csd_pkg::CSD_HIGH;
        end
        else if (!strap_pu[gi] && !strap_pd[gi])
        begin
          level[gi] = csd_pkg::CSD_LOW;
        end
        else
        begin
          level[gi] = csd_pkg::CSD_FLOAT; // Disagreeing senses treated as open
        end
      end
    end
  endgenerate

  // Next state: bus slave, decode and pin routing
  always_comb
  begin
    logic req;
    logic ext;
    csd_pkg::csd_level_t c_mode;
    csd_pkg::csd_level_t c_swing;
    csd_pkg::csd_level_t c_edge;
    csd_pkg::csd_level_t c_cal;
    req = 1'b0;
    ext = 1'b0;
    next_state = state;
    // [R11] Codes registered first
    next_state.code = level;
    c_mode = state.code[`CSD_STRAP_MODE];
    c_swing = state.code[`CSD_STRAP_SWING];
    c_edge = state.code[`CSD_STRAP_EDGE];
    c_cal = state.code[`CSD_STRAP_CAL];

    // [R1] Floating mode strap
    ext = (c_mode == csd_pkg::CSD_FLOAT);
    next_state.ext_mode = ext;

    // Hold freezes the pin-mode settings so software can sample them stable
    if (!state.hold)
    begin
      if (ext)
      begin
        // Functions move to the serial side; pin settings rest at low codes
        next_state.range_870 = 1'b0;
        next_state.swing_700 = 1'b0;
        next_state.edge_pos = 1'b0;
        next_state.ddr_mode = 1'b0;
        next_state.cal_long = 1'b0;
        next_state.des_enable = 1'b0;
      end
      else
      begin
        // [R3] Input range select
        next_state.range_870 = (c_mode == csd_pkg::CSD_HIGH);
        // [R4] Output swing select
        // Floating swing strap is not valid; it is read as low swing
        next_state.swing_700 = (c_swing == csd_pkg::CSD_HIGH);
        // [R6] DDR overrides edge
        next_state.ddr_mode = (c_edge == csd_pkg::CSD_FLOAT);
        // [R5] Data output edge
        next_state.edge_pos = (c_edge == csd_pkg::CSD_HIGH);
        // [R7] Calibration delay select
        next_state.cal_long = (c_cal == csd_pkg::CSD_HIGH);
        // [R8] Float gives dual-edge sampling
        next_state.des_enable = (c_cal == csd_pkg::CSD_FLOAT);
      end
    end

    // [R9] Serial pin reuse
    // [R2] Serial side idle in pin mode
    next_state.ser_clk = ext & strap_pd[`CSD_STRAP_SWING];
    next_state.ser_din = ext & strap_pd[`CSD_STRAP_EDGE];
    next_state.ser_cs = ext & strap_pd[`CSD_STRAP_CAL];
    next_state.edge_pin_out = ext & ser_sdo;
    next_state.edge_pin_oe = ext & ser_sdo_oe;

    // Bus slave: one wait cycle, then a one-cycle answer
    req = (avs_read || avs_write) && !state.ack;
    next_state.ack = req;
    if (req && avs_read)
    begin
      case (avs_address)
        `CSD_OFS_CTRL:
        begin
          next_state.rdata = {31'h0, state.hold};
        end
        `CSD_OFS_STATUS:
        begin
          next_state.rdata = {25'h0, state.des_enable, state.cal_long, state.ddr_mode,
            state.edge_pos, state.swing_700, state.range_870, state.ext_mode};
        end
        `CSD_OFS_STRAPS:
        begin
          next_state.rdata = {20'h0, state.code};
        end
        default:
        begin
          next_state.rdata = 32'h0; // Unmapped reads as zero
        end
      endcase
    end
    if (req && avs_write && avs_byteenable[0] && (avs_address == `CSD_OFS_CTRL))
    begin
      next_state.hold = avs_writedata[`CSD_CTRL_HOLD];
    end
  end

  // State register; reset acts even with clock enable low, which otherwise freezes everything
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state <= '0;
      state.hold <= `CSD_CTRL_RST;
      state.code <= {4{csd_pkg::CSD_LOW}};
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  // Outputs straight from state flops
  assign avs_readdata = state.rdata;
  assign avs_waitrequest = ~state.ack;
  assign extended_mode = state.ext_mode;
  assign range_870 = state.range_870;
  assign swing_700 = state.swing_700;
  assign output_edge_select = state.edge_pos;
  assign ddr_mode = state.ddr_mode;
  assign calibration_delay_select = state.cal_long;
  assign des_enable = state.des_enable;
  assign serial_clock_in = state.ser_clk;
  assign serial_chip_select = state.ser_cs;
  assign serial_data_in = state.ser_din;
  assign serial_data_line_out = state.edge_pin_out;
  assign serial_data_line_oe = state.edge_pin_oe;

endmodule

// *** design/csd_consts.svh ***
// Purpose: Offsets, field positions and reset values of the strap decoder
// Assumes: Included by bare name from the decoder module
// Notes: Definitions only
`ifndef CSD_CONSTS_SVH
`define CSD_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define CSD_OFS_CTRL 4'h0
`define CSD_OFS_STATUS 4'h4
`define CSD_OFS_STRAPS 4'h8

// Control fields
`define CSD_CTRL_HOLD 0
`define CSD_CTRL_RST 1'h0

// Status fields
`define CSD_ST_EXT 0
`define CSD_ST_RANGE 1
`define CSD_ST_SWING 2
`define CSD_ST_EDGE 3
`define CSD_ST_DDR 4
`define CSD_ST_CALLONG 5
`define CSD_ST_DES 6

// Strap indices
`define CSD_STRAP_SWING 0
`define CSD_STRAP_EDGE 1
`define CSD_STRAP_CAL 2
`define CSD_STRAP_MODE 3
`define CSD_NUM_STRAPS 4

`endif

// *** design/csd_pkg.sv ***
// Purpose: Types of the control mode strap decoder
// Assumes: Used with package scope only, never imported
// Notes: Strap levels are one-hot codes
package csd_pkg;

  // Resolved level of one tri-level strap
  typedef enum logic [2:0] {
    CSD_LOW = 3'h1,
    CSD_HIGH = 3'h2,
    CSD_FLOAT = 3'h4
  } csd_level_t;

  // All state of the decoder
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic hold;
    csd_level_t [3:0] code;
    logic ext_mode;
    logic range_870;
    logic swing_700;
    logic edge_pos;
    logic ddr_mode;
    logic cal_long;
    logic des_enable;
    logic ser_clk;
    logic ser_cs;
    logic ser_din;
    logic edge_pin_out;
    logic edge_pin_oe;
  } csd_state_t;

endpackage

// *** verification/csd_strap_wiring.sv ***
// Purpose: Board strap wiring model
// Assumes: lvl holds 2 bits per strap: 0 low, 1 high, 2 open
// Notes: An open pin follows whichever weak pull senses it
`timescale 1ns/100ps
module csd_strap_wiring (
  input wire logic [7:0] lvl,
  output logic [3:0] strap_pu,
  output logic [3:0] strap_pd
);
  // mode strap firm or open only
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      strap_pu[i] = lvl[2*i+:2] != 2'h0;
      strap_pd[i] = lvl[2*i+:2] == 2'h1;
    end
  end
endmodule

// *** verification/csd_properties.sv ***
// Purpose: Port checks of the strap decoder
// Assumes: clk_en held high
// Notes: Checks wait three edges after reset, while reset codes drain
`timescale 1ns/100ps
module csd_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] strap_pu,
  input wire logic [3:0] strap_pd,
  input wire logic ser_sdo,
  input wire logic ser_sdo_oe,
  input wire logic extended_mode,
  input wire logic range_870,
  input wire logic swing_700,
  input wire logic output_edge_select,
  input wire logic ddr_mode,
  input wire logic calibration_delay_select,
  input wire logic des_enable,
  input wire logic serial_clock_in,
  input wire logic serial_chip_select,
  input wire logic serial_data_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe
);
  logic [1:0] age;
  wire logic [3:0] fl = strap_pu ^ strap_pd;
  wire logic [3:0] hi = strap_pu & strap_pd;
  // Raw sources only; gating uses the mode flag of the same cycle as the outputs
  wire logic [4:0] src = {strap_pd[0], strap_pd[1], strap_pd[2], ser_sdo, ser_sdo_oe};
  wire logic [4:0] sout = {serial_clock_in, serial_data_in, serial_chip_select, serial_data_line_out,
    serial_data_line_oe};
  wire logic ok = age == 2'h3;
  wire logic pm = ok && !extended_mode;
  // Edges since reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      age <= 2'h0;
    else if (!ok)
      age <= age + 2'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_EXT: assert property (ok |-> extended_mode == $past(fl[3], 2))
    else $error("mode flag wrong");
  AST_SER: assert property (ok |-> sout == ($past(src) & {5{extended_mode}}))
    else $error("serial routing wrong");
  AST_RANGE: assert property (pm |-> range_870 == $past(hi[3], 2))
    else $error("range wrong");
  AST_SWING: assert property (pm |-> swing_700 == $past(hi[0], 2))
    else $error("swing wrong");
  AST_EDGE: assert property (pm |-> output_edge_select == $past(hi[1], 2))
    else $error("edge wrong");
  AST_DDR: assert property (pm |-> ddr_mode == $past(fl[1], 2))
    else $error("ddr wrong");
  AST_CAL: assert property (pm |-> calibration_delay_select == $past(hi[2], 2))
    else $error("cal delay wrong");
  AST_DES: assert property (pm |-> des_enable == $past(fl[2], 2))
    else $error("des wrong");
endmodule

bind csd_strap_decoder csd_checker u_chk (.sys_clk, .sys_rst, .strap_pu, .strap_pd, .ser_sdo, .ser_sdo_oe,
  .extended_mode, .range_870, .swing_700, .output_edge_select, .ddr_mode, .calibration_delay_select,
  .des_enable, .serial_clock_in, .serial_chip_select, .serial_data_in, .serial_data_line_out,
  .serial_data_line_oe);

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench of the strap decoder
// Assumes: Straps held still while a result is read
// Notes: Hold bit is only written and read back, its freeze is untested; clock enable is left untested
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic ser_sdo = 1'h0, ser_sdo_oe = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [3:0] avs_address = 4'h0, strap_pu, strap_pd;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [7:0] lvl = 8'h0;
  logic avs_waitrequest, extended_mode, range_870, swing_700, output_edge_select, ddr_mode, des_enable;
  logic calibration_delay_select, serial_clock_in, serial_chip_select, serial_data_in;
  logic serial_data_line_out, serial_data_line_oe;
  int n_fail = 0;
  int num_checks = 0;
  csd_strap_wiring u_wire (.lvl, .strap_pu, .strap_pd);
  csd_strap_decoder DUT (.sys_clk, .sys_rst, .clk_en(1'h1), .strap_pu, .strap_pd, .ser_sdo, .ser_sdo_oe,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1), .avs_readdata,
    .avs_waitrequest, .extended_mode, .range_870, .swing_700, .output_edge_select, .ddr_mode,
    .calibration_delay_select, .des_enable, .serial_clock_in, .serial_chip_select, .serial_data_in,
    .serial_data_line_out, .serial_data_line_oe);
  // Clock and watchdog
  initial forever #4 sys_clk = ~sys_clk;
  initial
  begin
    #20000;
    n_fail++;
    print_verdict();
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // One access; release one edge after the answer
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge sys_clk);
    for (n = 0; n < 20 && avs_waitrequest !== 1'h0; n++)
      @(posedge sys_clk);
    // No answer within the limit counts as a mismatch
    if (n == 20)
    begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, 1'h1, 1'h0);
    end
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'h0;
    // mode strap driven in pin mode
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 2; s++)
        for (int e = 0; e < 3; e++)
          for (int c = 0; c < 3; c++)
          begin
            lvl <= {m[1:0], c[1:0], e[1:0], s[1:0]};
            repeat (3) @(posedge sys_clk);
            bus(1'h0, 4'h4, 32'h0);
            chk(q, {25'h0, c == 2, c == 1, e == 2, e == 1, s == 1, m == 1, 1'h0});
            bus(1'h0, 4'h8, 32'h0);
            chk(q, {20'h0, 3'h1 << m, 3'h1 << c, 3'h1 << e, 3'h1 << s});
          end
    $display("test pin mode done");
    // Open mode strap, pins carry serial traffic
    for (int k = 0; k < 8; k++)
    begin
      lvl <= {2'h2, 1'h0, k[2], 1'h0, k[1], 1'h0, k[0]};
      ser_sdo <= k[0];
      ser_sdo_oe <= k[1];
      repeat (3) @(posedge sys_clk);
      chk({serial_clock_in, serial_data_in, serial_chip_select, serial_data_line_out, serial_data_line_oe},
        {k[0], k[1], k[2], k[0], k[1]});
      bus(1'h0, 4'h4, 32'h0);
      chk(q, 32'h1);
    end
    $display("test extended mode done");
    // Control word, then unmapped place
    bus(1'h1, 4'h0, 32'h1);
    bus(1'h0, 4'h0, 32'h0);
    chk(q, 32'h1);
    bus(1'h1, 4'h0, 32'h0);
    bus(1'h0, 4'h0, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, 4'hc, 32'h1);
    bus(1'h0, 4'hc, 32'h0);
    chk(q, 32'h0);
    bus(1'h0, 4'h0, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    print_verdict();
  end
endmodule
